/* rtl/psc_defs.vh */
// Address map, field positions, reset values and rate figures of the sensor control block
`ifndef PSC_DEFS_VH
`define PSC_DEFS_VH

// =====================================================================
// Register addresses (7-bit serial register address)
`define PSC_ADDR_IRQ_CFG 7'h0b
`define PSC_ADDR_THS_LOW 7'h0c
`define PSC_ADDR_THS_HIGH 7'h0d
`define PSC_ADDR_IF_CTRL 7'h0e
`define PSC_ADDR_IDENTITY 7'h0f
`define PSC_ADDR_ACQ_CTRL1 7'h10
`define PSC_ADDR_ACQ_CTRL2 7'h11
`define PSC_ADDR_RES_XL 7'h28
`define PSC_ADDR_RES_L 7'h29
`define PSC_ADDR_RES_H 7'h2a

// =====================================================================
// Field positions
`define PSC_IRQCFG_DIFFERENTIAL_IRQ_ENABLE 3
`define PSC_IRQCFG_LOW_EN 1
`define PSC_IRQCFG_HIGH_EN 0
`define PSC_IF_DATA_PU 4
`define PSC_IF_SOUT_PU 3
`define PSC_IF_PD_DIS 2
`define PSC_IF_I2C_DIS 0
`define PSC_C1_RATE_MSB 6
`define PSC_C1_RATE_LSB 4
`define PSC_C1_FILT_EN 3
`define PSC_C1_FILT_CFG 2
`define PSC_C1_HOLD 1
`define PSC_C1_SPI_3W 0
`define PSC_C2_LOW_NOISE 1
`define PSC_C2_ONE_SHOT 0

// =====================================================================
// Reset values and fixed-zero masks
`define PSC_RESET_BYTE 8'h00
`define PSC_READ_ZERO 8'h00
`define PSC_THS_HIGH_MASK 8'h7f
`define PSC_IF_CTRL_MASK 8'h1d
`define PSC_ACQ_CTRL1_MASK 8'h7f

// =====================================================================
// Rate codes, rates and bandwidth divisors
`define PSC_RATE_OFF 3'h0
`define PSC_RATE_NO_LOW_NOISE 3'h6
`define PSC_HZ_1 1
`define PSC_HZ_10 10
`define PSC_HZ_25 25
`define PSC_HZ_50 50
`define PSC_HZ_75 75
`define PSC_HZ_100 100
`define PSC_HZ_200 200
`define PSC_BW_DIV_OFF 5'h02
`define PSC_BW_DIV_MID 5'h09
`define PSC_BW_DIV_NARROW 5'h14
`define PSC_THS_SCALE_BITS 8

`endif

/* rtl/psc_rate_timer.v */
// Acquisition period timer for the continuous output rates
`timescale 1ns/100ps

module psc_rate_timer
#(
    parameter CLK_HZ = 40000000,
    parameter CNT_W = 26
)
(
    // Clock and reset
    input wire clk,
    input wire rst,
    // Rate selection
    input wire [2:0] rateCode,
    // One pulse per period
    output reg tick
);

`include "psc_defs.vh"

// =====================================================================
// Period per rate code
function [CNT_W-1:0] periodFor;
    input [2:0] code;
    integer cycles;
    begin
        case (code)
            3'h1: cycles = CLK_HZ / `PSC_HZ_1 - 1;
            3'h2: cycles = CLK_HZ / `PSC_HZ_10 - 1;
            3'h3: cycles = CLK_HZ / `PSC_HZ_25 - 1;
            3'h4: cycles = CLK_HZ / `PSC_HZ_50 - 1;
            3'h5: cycles = CLK_HZ / `PSC_HZ_75 - 1;
            3'h6: cycles = CLK_HZ / `PSC_HZ_100 - 1;
            3'h7: cycles = CLK_HZ / `PSC_HZ_200 - 1;
            default: cycles = 0;
        endcase
        // CNT_W must cover the slowest period; the count is cut to it here
        periodFor = cycles[CNT_W-1:0];
    end
endfunction

reg [CNT_W-1:0] count_r;
reg [2:0] lastCode_r;

// Restart the period whenever the rate changes, so a new rate takes effect at once
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        count_r <= {CNT_W{1'b0}};
        lastCode_r <= `PSC_RATE_OFF;
        tick <= 1'b0;
    end
    else
    begin
        lastCode_r <= rateCode;
        tick <= 1'b0;
        if (rateCode == `PSC_RATE_OFF || rateCode != lastCode_r)
            count_r <= periodFor(rateCode);
        else if (count_r == {CNT_W{1'b0}})
        begin
            count_r <= periodFor(rateCode);
            tick <= 1'b1;
        end
        else
            count_r <= count_r - 1'b1;
    end
end

endmodule // psc_rate_timer

/* rtl/psc_result_hold.v */
// Pressure result register with block-update hold
`timescale 1ns/100ps

module psc_result_hold
#(
    parameter RES_W = 24
)
(
    // Clock and reset
    input wire clk,
    input wire rst,
    // Control
    input wire holdEnable,
    // New sample
    input wire loadValid,
    input wire [RES_W-1:0] loadData,
    // Byte read strobes
    input wire readXl,
    input wire readL,
    input wire readH,
    // Held result
    output reg [RES_W-1:0] result,
    output reg locked
);

reg [1:0] seen_r;

// Lock on a fresh sample; release when the high byte closes a full read or when hold is disabled
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        result <= {RES_W{1'b0}};
        locked <= 1'b0;
        seen_r <= 2'h0;
    end
    else
    begin
        if (readXl)
            seen_r[0] <= 1'b1;
        if (readL)
            seen_r[1] <= 1'b1;
        if (!holdEnable)
        begin
            locked <= 1'b0;
            seen_r <= 2'h0;
        end
        else if (readH && (seen_r == 2'h3 || (seen_r[1] && readXl) || (seen_r[0] && readL)))
        begin
            locked <= 1'b0;
            seen_r <= 2'h0;
        end
        if (loadValid && !(holdEnable && locked))
        begin
            result <= loadData;
            locked <= holdEnable;
            seen_r <= 2'h0;
        end
    end
end

endmodule // psc_result_hold

/* rtl/psc_sensor_ctrl.v */
// Configuration registers and acquisition control of the pressure sensor
`timescale 1ns/100ps

// Behaviour
// - Threshold is 15-bit unsigned: low register bits 7..0, high register bits 14..8.
// - Threshold events only with differential enable and high or low enable set.
// - Both threshold registers read/write, reset zero; high holds bits 14..8.
// - Pad options: data pull-up bit4, serial-out pull-up bit3, irq pull-down disable bit2.
// - Interface control bit0 disables I2C; zero at reset, both interfaces active.
// - Rate field bits 6..4: 000 one-shot/off, then 1 to 200 Hz.
// - Rate codes 110 and 111 force low-noise mode off.
// - Rate 000 is power-down: registers kept, results not updated.
// - One-shot accepted only in power-down with rate 000.
// - One-shot does one acquisition, updates results, then clears itself.
// - Nonzero rate runs continuously, one data set per period.
// - Filter enable bit3 filters pressure in continuous mode; else bypassed.
// - Bandwidth is rate/2, rate/9 or rate/20 by filter enable and config.
// - Block update holds results until extra-low, low and high bytes are read.
// - Control one bit0 selects 4-wire SPI at zero, 3-wire at one.
// - One-shot is control two bit0, reset zero; one requests a new set.
// - High enable fires above threshold; low enable fires below negative threshold.
module psc_sensor_ctrl
#(
    parameter CLK_HZ = 40000000,
    parameter CNT_W = 26,
    parameter RES_W = 24,
    parameter [7:0] IDENTITY_CODE = 8'h5a // Arbitrary value
)
(
    // Clock and reset
    input wire clk,
    input wire rst,
    // Register access from the serial interface
    input wire [6:0] regAddr,
    input wire regWrEn,
    input wire [7:0] regWrData,
    input wire regRdEn,
    output reg [7:0] regRdData,
    // Conversion datapath
    input wire sampleValid,
    input wire [RES_W-1:0] samplePressure,
    input wire [RES_W-1:0] pressureDiff,
    output reg acqStart,
    output reg acqBusy,
    // Pad and interface controls
    output reg dataLinePullupEn,
    output reg serialOutPullupEn,
    output reg irqPadPulldownEn,
    output reg i2cEnable,
    output reg spiThreeWire,
    // Acquisition mode status
    output reg [2:0] rateSelect,
    output reg powerDown,
    output reg lowNoiseActive,
    output reg filterActive,
    output reg filterConfig,
    output reg [4:0] bandwidthDiv,
    // Threshold events
    output reg irqHighEvent,
    output reg irqLowEvent
);

`include "psc_defs.vh"

// =====================================================================
// Configuration storage
reg [7:0] thsLow_r;
reg [6:0] thsHigh_r;
reg diffEnable_r;
reg lowEventEnable_r;
reg highEventEnable_r;
reg dataPullup_r;
reg soutPullup_r;
reg pulldownDisable_r;
reg i2cDisable_r;
reg [2:0] rate_r;
reg filtEnable_r;
reg filtCfg_r;
reg holdEnable_r;
reg spi3w_r;
reg lowNoiseReq_r;
reg oneShot_r;
reg inFlight_r;

wire [14:0] thresholdBits;
wire [RES_W-1:0] heldResult;
wire holdLocked;
wire rateTick;
wire wrThsLow;
wire wrThsHigh;
wire wrIrqCfg;
wire wrIfCtrl;
wire wrCtrl1;
wire wrCtrl2;
wire rdResXl;
wire rdResL;
wire rdResH;
wire oneShotAccept;
wire contStart;
wire doneSample;

// =====================================================================
// Address decode
function isAccess;
    input [6:0] addr;
    input [6:0] target;
    input strobe;
    begin
        isAccess = strobe && (addr == target);
    end
endfunction

assign wrIrqCfg = isAccess(regAddr, `PSC_ADDR_IRQ_CFG, regWrEn);
assign wrThsLow = isAccess(regAddr, `PSC_ADDR_THS_LOW, regWrEn);
assign wrThsHigh = isAccess(regAddr, `PSC_ADDR_THS_HIGH, regWrEn);
assign wrIfCtrl = isAccess(regAddr, `PSC_ADDR_IF_CTRL, regWrEn);
assign wrCtrl1 = isAccess(regAddr, `PSC_ADDR_ACQ_CTRL1, regWrEn);
assign wrCtrl2 = isAccess(regAddr, `PSC_ADDR_ACQ_CTRL2, regWrEn);
assign rdResXl = isAccess(regAddr, `PSC_ADDR_RES_XL, regRdEn);
assign rdResL = isAccess(regAddr, `PSC_ADDR_RES_L, regRdEn);
assign rdResH = isAccess(regAddr, `PSC_ADDR_RES_H, regRdEn);

assign thresholdBits = {thsHigh_r, thsLow_r};

// =====================================================================
// Configuration registers
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        thsLow_r <= `PSC_RESET_BYTE;
        thsHigh_r <= 7'h00;
        diffEnable_r <= 1'b0;
        lowEventEnable_r <= 1'b0;
        highEventEnable_r <= 1'b0;
        dataPullup_r <= 1'b0;
        soutPullup_r <= 1'b0;
        pulldownDisable_r <= 1'b0;
        i2cDisable_r <= 1'b0;
        rate_r <= `PSC_RATE_OFF;
        filtEnable_r <= 1'b0;
        filtCfg_r <= 1'b0;
        holdEnable_r <= 1'b0;
        spi3w_r <= 1'b0;
        lowNoiseReq_r <= 1'b0;
    end
    else
    begin
        if (wrThsLow)
            thsLow_r <= regWrData;
        if (wrThsHigh)
            thsHigh_r <= regWrData[6:0];
        if (wrIrqCfg)
        begin
            diffEnable_r <= regWrData[`PSC_IRQCFG_DIFFERENTIAL_IRQ_ENABLE];
            lowEventEnable_r <= regWrData[`PSC_IRQCFG_LOW_EN];
            highEventEnable_r <= regWrData[`PSC_IRQCFG_HIGH_EN];
        end
        if (wrIfCtrl)
        begin
            dataPullup_r <= regWrData[`PSC_IF_DATA_PU];
            soutPullup_r <= regWrData[`PSC_IF_SOUT_PU];
            pulldownDisable_r <= regWrData[`PSC_IF_PD_DIS];
            i2cDisable_r <= regWrData[`PSC_IF_I2C_DIS];
        end
        if (wrCtrl1)
        begin
            rate_r <= regWrData[`PSC_C1_RATE_MSB:`PSC_C1_RATE_LSB];
            filtEnable_r <= regWrData[`PSC_C1_FILT_EN];
            filtCfg_r <= regWrData[`PSC_C1_FILT_CFG];
            holdEnable_r <= regWrData[`PSC_C1_HOLD];
            spi3w_r <= regWrData[`PSC_C1_SPI_3W];
        end
        if (wrCtrl2)
            lowNoiseReq_r <= regWrData[`PSC_C2_LOW_NOISE];
    end
end

// =====================================================================
// Acquisition sequencing
// Only one conversion may be outstanding; a period tick during one is skipped
assign oneShotAccept = wrCtrl2 && regWrData[`PSC_C2_ONE_SHOT] && rate_r == `PSC_RATE_OFF
    && !oneShot_r && !inFlight_r;
assign contStart = rateTick && rate_r != `PSC_RATE_OFF && !inFlight_r;
assign doneSample = sampleValid && inFlight_r;

always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        oneShot_r <= 1'b0;
        inFlight_r <= 1'b0;
        acqStart <= 1'b0;
    end
    else
    begin
        acqStart <= oneShotAccept || contStart;
        if (oneShotAccept || contStart)
            inFlight_r <= 1'b1;
        else if (doneSample)
            inFlight_r <= 1'b0;
        if (oneShotAccept)
            oneShot_r <= 1'b1;
        else if (doneSample)
            oneShot_r <= 1'b0;
    end
end

psc_rate_timer
#(
    .CLK_HZ(CLK_HZ),
    .CNT_W(CNT_W)
)
u_rate_timer
(
    .clk(clk),
    .rst(rst),
    .rateCode(rate_r),
    .tick(rateTick)
);

// =====================================================================
// Result register; samples only arrive from started conversions
psc_result_hold
#(
    .RES_W(RES_W)
)
u_result_hold
(
    .clk(clk),
    .rst(rst),
    .holdEnable(holdEnable_r),
    .loadValid(doneSample),
    .loadData(samplePressure),
    .readXl(rdResXl),
    .readL(rdResL),
    .readH(rdResH),
    .result(heldResult),
    .locked(holdLocked)
);

// =====================================================================
// Threshold comparison against the differential pressure
// Threshold counts are 1/16 hPa, result counts 1/4096 hPa: scale by 256
wire signed [RES_W:0] diffExt;
wire signed [RES_W:0] thsExt;
wire diffAbove;
wire diffBelow;
wire thsArmed;

assign diffExt = {pressureDiff[RES_W-1], pressureDiff};
assign thsExt = {{(RES_W-14-`PSC_THS_SCALE_BITS){1'b0}}, thresholdBits, {`PSC_THS_SCALE_BITS{1'b0}}};
assign diffAbove = diffExt > thsExt;
assign diffBelow = diffExt < -thsExt;
assign thsArmed = diffEnable_r && (highEventEnable_r || lowEventEnable_r);

always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        irqHighEvent <= 1'b0;
        irqLowEvent <= 1'b0;
    end
    else
    begin
        irqHighEvent <= doneSample && thsArmed && highEventEnable_r && diffAbove;
        irqLowEvent <= doneSample && thsArmed && lowEventEnable_r && diffBelow;
    end
end

// =====================================================================
// Mode outputs
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        dataLinePullupEn <= 1'b0;
        serialOutPullupEn <= 1'b0;
        irqPadPulldownEn <= 1'b1;
        i2cEnable <= 1'b1;
        spiThreeWire <= 1'b0;
        rateSelect <= `PSC_RATE_OFF;
        powerDown <= 1'b1;
        lowNoiseActive <= 1'b0;
        filterActive <= 1'b0;
        filterConfig <= 1'b0;
        bandwidthDiv <= `PSC_BW_DIV_OFF;
        acqBusy <= 1'b0;
    end
    else
    begin
        dataLinePullupEn <= dataPullup_r;
        serialOutPullupEn <= soutPullup_r;
        irqPadPulldownEn <= !pulldownDisable_r;
        i2cEnable <= !i2cDisable_r;
        spiThreeWire <= spi3w_r;
        rateSelect <= rate_r;
        powerDown <= rate_r == `PSC_RATE_OFF && !inFlight_r;
        lowNoiseActive <= lowNoiseReq_r && rate_r < `PSC_RATE_NO_LOW_NOISE;
        filterActive <= filtEnable_r && rate_r != `PSC_RATE_OFF;
        filterConfig <= filtCfg_r;
        if (!filtEnable_r)
            bandwidthDiv <= `PSC_BW_DIV_OFF;
        else if (filtCfg_r)
            bandwidthDiv <= `PSC_BW_DIV_NARROW;
        else
            bandwidthDiv <= `PSC_BW_DIV_MID;
        acqBusy <= inFlight_r;
    end
end

// =====================================================================
// Read-back; unmapped addresses read zero
reg [7:0] rdMux;

always @*
begin
    rdMux = `PSC_READ_ZERO;
    case (regAddr)
        `PSC_ADDR_IRQ_CFG:
        begin
            rdMux[`PSC_IRQCFG_DIFFERENTIAL_IRQ_ENABLE] = diffEnable_r;
            rdMux[`PSC_IRQCFG_LOW_EN] = lowEventEnable_r;
            rdMux[`PSC_IRQCFG_HIGH_EN] = highEventEnable_r;
        end
        `PSC_ADDR_THS_LOW: rdMux = thsLow_r;
        `PSC_ADDR_THS_HIGH: rdMux = {1'b0, thsHigh_r} & `PSC_THS_HIGH_MASK;
        `PSC_ADDR_IF_CTRL:
        begin
            rdMux[`PSC_IF_DATA_PU] = dataPullup_r;
            rdMux[`PSC_IF_SOUT_PU] = soutPullup_r;
            rdMux[`PSC_IF_PD_DIS] = pulldownDisable_r;
            rdMux[`PSC_IF_I2C_DIS] = i2cDisable_r;
            rdMux = rdMux & `PSC_IF_CTRL_MASK;
        end
        `PSC_ADDR_IDENTITY: rdMux = IDENTITY_CODE;
        `PSC_ADDR_ACQ_CTRL1:
        begin
            rdMux[`PSC_C1_RATE_MSB:`PSC_C1_RATE_LSB] = rate_r;
            rdMux[`PSC_C1_FILT_EN] = filtEnable_r;
            rdMux[`PSC_C1_FILT_CFG] = filtCfg_r;
            rdMux[`PSC_C1_HOLD] = holdEnable_r;
            rdMux[`PSC_C1_SPI_3W] = spi3w_r;
            rdMux = rdMux & `PSC_ACQ_CTRL1_MASK;
        end
        `PSC_ADDR_ACQ_CTRL2:
        begin
            rdMux[`PSC_C2_LOW_NOISE] = lowNoiseReq_r;
            rdMux[`PSC_C2_ONE_SHOT] = oneShot_r;
        end
        `PSC_ADDR_RES_XL: rdMux = heldResult[7:0];
        `PSC_ADDR_RES_L: rdMux = heldResult[15:8];
        `PSC_ADDR_RES_H: rdMux = heldResult[23:16];
        default: rdMux = `PSC_READ_ZERO;
    endcase
end

// Data holds between reads so a slow serial shifter can take it at leisure
always @(posedge clk or posedge rst)
begin
    if (rst)
        regRdData <= `PSC_READ_ZERO;
    else if (regRdEn)
        regRdData <= rdMux;
end

endmodule // psc_sensor_ctrl

/* verif/psc_conv_model.sv */
// Behavioural conversion datapath on the far side of the control block
`timescale 1ns/100ps

module psc_conv_model
#(
    parameter LAT = 5,
    parameter [23:0] STEP = 24'h010203
)
(
    // Clock and reset
    input wire clk,
    input wire rst,
    // Control side
    input wire acqStart,
    input wire [23:0] diffIn,
    // Sample side
    output reg sampleValid,
    output reg [23:0] samplePressure,
    output reg [23:0] pressureDiff
);
    integer cnt;
    reg [23:0] num_r;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt <= 0;
            num_r <= 24'h000000;
            sampleValid <= 1'b0;
            samplePressure <= 24'h000000;
            pressureDiff <= 24'h000000;
        end
        else
        begin
            sampleValid <= 1'b0;
            // Data is only good with the strobe; scramble it otherwise
            samplePressure <= ~samplePressure;
            pressureDiff <= ~pressureDiff;
            if (acqStart)
                cnt <= LAT;
            else if (cnt > 1)
                cnt <= cnt - 1;
            else if (cnt == 1)
            begin
                cnt <= 0;
                num_r <= num_r + 24'h000001;
                sampleValid <= 1'b1;
                samplePressure <= (num_r + 24'h000001) * STEP;
                pressureDiff <= diffIn;
            end
        end
    end
endmodule // psc_conv_model

/* verif/psc_sensor_ctrl_checker.sv */
// Port-level assertions for the sensor control block
`timescale 1ns/100ps

module psc_sensor_ctrl_checker
#(
    parameter [7:0] IDENTITY_CODE = 8'h5a
)
(
    // Clock and reset
    input wire clk,
    input wire rst,
    // Register access
    input wire [6:0] regAddr,
    input wire regWrEn,
    input wire [7:0] regWrData,
    input wire regRdEn,
    input wire [7:0] regRdData,
    // Datapath and status
    input wire sampleValid,
    input wire acqStart,
    input wire irqHighEvent,
    input wire irqLowEvent,
    input wire irqPadPulldownEn,
    input wire i2cEnable,
    input wire spiThreeWire,
    input wire [2:0] rateSelect,
    input wire powerDown,
    input wire lowNoiseActive,
    input wire filterActive,
    input wire filterConfig,
    input wire [4:0] bandwidthDiv
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ==========
    // Assertions
    a_start_pulse: assert property (acqStart |=> !acqStart)
        else $error("start pulse too long");
    a_pulldown_bit: assert property (regWrEn && regAddr == 7'h0e |-> ##2 irqPadPulldownEn == !$past(regWrData[2], 2))
        else $error("pull-down control wrong");
    a_i2c_bit: assert property (regWrEn && regAddr == 7'h0e |-> ##2 i2cEnable == !$past(regWrData[0], 2))
        else $error("i2c enable wrong");
    a_spi_mode: assert property (regWrEn && regAddr == 7'h10 |-> ##2 spiThreeWire == $past(regWrData[0], 2))
        else $error("spi wire mode wrong");
    a_rate_copy: assert property (regWrEn && regAddr == 7'h10 |-> ##2 rateSelect == $past(regWrData[6:4], 2))
        else $error("rate select wrong");
    a_noise_off: assert property (rateSelect >= 3'h6 |-> !lowNoiseActive)
        else $error("low noise at high rate");
    a_filter_bw: assert property (filterActive |-> bandwidthDiv == (filterConfig ? 5'h14 : 5'h09))
        else $error("bandwidth divisor wrong");
    a_run_mode: assert property (rateSelect != 3'h0 |-> !powerDown)
        else $error("power-down while running");
    a_id_read: assert property (regRdEn && regAddr == 7'h0f |=> regRdData == IDENTITY_CODE)
        else $error("identity read wrong");
    a_event_cause: assert property (irqHighEvent || irqLowEvent |-> $past(sampleValid) && !(irqHighEvent && irqLowEvent))
        else $error("event without sample");
endmodule // psc_sensor_ctrl_checker

/* verif/tb_psc_sensor_ctrl.sv */
// Self-checking bench for the sensor control block
`timescale 1ns/100ps

module tb_psc_sensor_ctrl;
    localparam [7:0] ID = 8'h3c; // Arbitrary value
    localparam [23:0] STEP = 24'h010203;
    localparam bit [22:0] ROWS [6] = '{{7'h0c, 8'hff, 8'hff}, {7'h0d, 8'hff, 8'h7f}, {7'h0e, 8'hff, 8'h1d},
        {7'h10, 8'h7f, 8'h7f}, {7'h0f, 8'hff, ID}, {7'h05, 8'hff, 8'h00}};
    localparam bit [33:0] EV [5] = '{{8'h0b, 24'h001001, 2'b10}, {8'h0b, 24'h001000, 2'b00},
        {8'h0b, 24'hffefff, 2'b01}, {8'h03, 24'h001001, 2'b00}, {8'h09, 24'hffefff, 2'b00}};
    reg clk, rst, regWrEn, regRdEn;
    reg [6:0] regAddr;
    reg [7:0] regWrData, rdv;
    reg [23:0] diffVal, expA;
    wire sampleValid, acqStart, acqBusy, dataLinePullupEn, serialOutPullupEn, irqPadPulldownEn;
    wire i2cEnable, spiThreeWire, powerDown, lowNoiseActive, filterActive, filterConfig;
    wire irqHighEvent, irqLowEvent;
    wire [23:0] samplePressure, pressureDiff;
    wire [7:0] regRdData;
    wire [2:0] rateSelect;
    wire [4:0] bandwidthDiv;
    integer failures, cmp_count, cyc, nSamp, hiCnt, loCnt, stCnt, i, k;

`define CHK(got, exp) \
    begin \
        cmp_count = cmp_count + 1; \
        if ((got) !== (exp)) \
        begin \
            failures = failures + 1; \
            $display("unexpected at %0t: got %h want %h", $time, got, exp); \
        end \
    end

    psc_sensor_ctrl #(.CLK_HZ(8000), .IDENTITY_CODE(ID)) dut_u (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .sampleValid(sampleValid), .samplePressure(samplePressure), .pressureDiff(pressureDiff),
        .acqStart(acqStart), .acqBusy(acqBusy), .dataLinePullupEn(dataLinePullupEn),
        .serialOutPullupEn(serialOutPullupEn), .irqPadPulldownEn(irqPadPulldownEn), .i2cEnable(i2cEnable),
        .spiThreeWire(spiThreeWire), .rateSelect(rateSelect), .powerDown(powerDown),
        .lowNoiseActive(lowNoiseActive), .filterActive(filterActive), .filterConfig(filterConfig),
        .bandwidthDiv(bandwidthDiv), .irqHighEvent(irqHighEvent), .irqLowEvent(irqLowEvent));

    psc_conv_model #(.LAT(5), .STEP(STEP)) conv_u (.clk(clk), .rst(rst), .acqStart(acqStart),
        .diffIn(diffVal), .sampleValid(sampleValid), .samplePressure(samplePressure),
        .pressureDiff(pressureDiff));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Counted on the falling edge, where the registered outputs have settled
    always @(negedge clk)
    begin
        cyc = cyc + 1;
        nSamp = nSamp + (sampleValid === 1'b1);
        hiCnt = hiCnt + (irqHighEvent === 1'b1);
        loCnt = loCnt + (irqLowEvent === 1'b1);
        stCnt = stCnt + (acqStart === 1'b1);
        if (cyc == 6000)
        begin
            failures = failures + 1;
            test_done;
        end
    end

    task test_done;
    begin
        $display("failures %0d comparisons %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask

    // ==========
    // Bus cycles: strobe one cycle, released after the taking edge
    task wr(input [6:0] a, input [7:0] d);
    begin
        @(posedge clk);
        #1;
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge clk);
        #1;
        regWrEn = 1'b0;
    end
    endtask

    task rd(input [6:0] a);
    begin
        @(posedge clk);
        #1;
        regAddr = a;
        regRdEn = 1'b1;
        @(posedge clk);
        #1;
        regRdEn = 1'b0;
        rdv = regRdData;
    end
    endtask

    task rdres(input [23:0] e);
    begin
        rd(7'h28);
        `CHK(rdv, e[7:0])
        rd(7'h29);
        `CHK(rdv, e[15:8])
        rd(7'h2a);
        `CHK(rdv, e[23:16])
    end
    endtask

    task oneshot;
        integer t;
    begin
        wr(7'h11, 8'h03);
        rd(7'h11);
        `CHK(rdv[0], 1'b1)
        `CHK(acqBusy, 1'b1)
        t = 0;
        while (sampleValid !== 1'b1 && t < 20)
        begin
            @(posedge clk);
            #1;
            t = t + 1;
        end
        `CHK(t < 20, 1'b1)
        repeat (2) @(posedge clk);
        #1;
        `CHK(acqBusy, 1'b0)
    end
    endtask

    // ==========
    // Main sequence
    initial
    begin
        {regWrEn, regRdEn, regAddr, regWrData, diffVal} = 0;
        {failures, cmp_count, cyc, nSamp, hiCnt, loCnt, stCnt} = 0;
        rst = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        `CHK({dataLinePullupEn, serialOutPullupEn, irqPadPulldownEn, i2cEnable, spiThreeWire}, 5'b00110)
        `CHK({powerDown, bandwidthDiv}, 6'h22)
        for (i = 0; i < 4; i = i + 1)
        begin
            rd(ROWS[i][22:16]);
            `CHK(rdv, 8'h00)
        end
        for (i = 0; i < 6; i = i + 1)
        begin
            wr(ROWS[i][22:16], ROWS[i][15:8]);
            rd(ROWS[i][22:16]);
            `CHK(rdv, ROWS[i][7:0])
        end
        `CHK({dataLinePullupEn, serialOutPullupEn, irqPadPulldownEn, i2cEnable}, 4'b1100)
        wr(7'h10, 8'h00);
        wr(7'h11, 8'h02);
        for (k = 0; k < 8; k = k + 1)
        begin
            wr(7'h10, {1'b0, k[2:0], 1'b1, k[0], 2'b00});
            repeat (8) @(posedge clk);
            #1;
            `CHK(rateSelect, k[2:0])
            `CHK(powerDown, k == 0)
            `CHK(lowNoiseActive, k < 6)
            `CHK(filterActive, k != 0)
            `CHK(filterConfig, k[0])
            if (k != 0)
                `CHK(bandwidthDiv, k[0] ? 5'h14 : 5'h09)
        end
        // Continuous at the fastest rate, filter off
        wr(7'h10, 8'h70);
        stCnt = 0;
        repeat (205) @(posedge clk);
        #1;
        `CHK(stCnt >= 4 && stCnt <= 5, 1'b1)
        `CHK(bandwidthDiv, 5'h02)
        wr(7'h10, 8'h00);
        repeat (10) @(posedge clk);
        oneshot;
        rdres(nSamp * STEP);
        rd(7'h11);
        `CHK(rdv, 8'h02)
        repeat (50) @(posedge clk);
        `CHK(stCnt, 5 + 1)
        rdres(nSamp * STEP);
        // One-shot refused while running
        wr(7'h10, 8'h10);
        stCnt = 0;
        wr(7'h11, 8'h03);
        rd(7'h11);
        `CHK(rdv, 8'h02)
        repeat (10) @(posedge clk);
        `CHK(stCnt, 0)
        wr(7'h10, 8'h00);
        // Held result survives a later sample; host reads high byte last
        wr(7'h10, 8'h02);
        oneshot;
        expA = nSamp * STEP;
        oneshot;
        rdres(expA);
        oneshot;
        rdres(nSamp * STEP);
        wr(7'h10, 8'h00);
        // One hectopascal threshold
        wr(7'h0c, 8'h10);
        wr(7'h0d, 8'h00);
        for (i = 0; i < 5; i = i + 1)
        begin
            wr(7'h0b, EV[i][33:26]);
            diffVal = EV[i][25:2];
            hiCnt = 0;
            loCnt = 0;
            oneshot;
            `CHK(hiCnt, EV[i][1])
            `CHK(loCnt, EV[i][0])
        end
        test_done;
    end
endmodule // tb_psc_sensor_ctrl

bind psc_sensor_ctrl psc_sensor_ctrl_checker #(.IDENTITY_CODE(IDENTITY_CODE)) chk_u (.clk(clk), .rst(rst),
    .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .sampleValid(sampleValid), .acqStart(acqStart), .irqHighEvent(irqHighEvent), .irqLowEvent(irqLowEvent),
    .irqPadPulldownEn(irqPadPulldownEn), .i2cEnable(i2cEnable), .spiThreeWire(spiThreeWire),
    .rateSelect(rateSelect), .powerDown(powerDown), .lowNoiseActive(lowNoiseActive),
    .filterActive(filterActive), .filterConfig(filterConfig), .bandwidthDiv(bandwidthDiv));
